/* dv/standby_ctl_assertions.sv */
// Purpose: Port assertions for standby_ctl
// Assumes: Settle count taken from SETTLE_FULL_CYCLES
// Notes: Bound to the design after endmodule
`timescale 1ns/1ps
`include "standby_ctl_defs.svh"
module standby_ctl_assertions
#(
    parameter int NUM_IRQ = 6,
    parameter logic [`SETTLE_CNT_W-1:0] SETTLE_FULL_CYCLES = 24'h0f0000
)
(
    // Clock, reset and requests
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic stop_req,
    input wire logic [`WAKE_COND_W-1:0] stop_operand,
    input wire logic ce_reset,
    input wire logic ce_counter_running,
    input wire logic ce_pin,
    input wire logic [3:0] wake_input_port,
    input wire logic [NUM_IRQ-1:0] irq_enable_bit,
    input wire logic [NUM_IRQ-1:0] irq_request_bit,
    input wire logic serial_ext_clk_sel,
    // Outputs watched
    input wire logic ce_counter_running_flag,
    input wire logic pc_hold,
    input wire logic osc_enable,
    input wire logic periph_run,
    input wire logic serial_run,
    input wire logic pll_enable,
    input wire logic ctrl_reg_init,
    input wire logic special_pins_to_port,
    input wire logic resume_pulse,
    input wire logic [1:0] power_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [3:0] op_ff;
    logic [23:0] cnt_ff;
    // Wake operand held through stop, settle cycles counted
    always_ff @(posedge ref_clk)
    begin
        if (power_state == 2'h0)
            op_ff <= stop_operand;
        cnt_ff <= (power_state == 2'h3) ? cnt_ff + 24'h1 : 24'h0;
    end
    sequence s_stop2;
        power_state == 2'h2 ##1 power_state == 2'h2;
    endsequence
    sequence s_ce_low;
        !ce_pin [*4];
    endsequence
    a_stop_init: assert property ($past(power_state) == 2'h0 && power_state == 2'h2 |-> ctrl_reg_init)
        else $error("no init pulse on stop entry");
    a_counter_noop: assert property (stop_req && ce_counter_running && power_state == 2'h0 |=> power_state != 2'h2)
        else $error("stop taken while counter runs");
    a_flag_follows: assert property (!$past(rst) |-> ce_counter_running_flag == $past(ce_counter_running))
        else $error("counter flag wrong");
    a_stop_quiet: assert property (s_stop2 |-> !osc_enable && !periph_run && pc_hold && special_pins_to_port)
        else $error("stop outputs wrong");
    a_halt_runs: assert property (power_state == 2'h1 && $past(power_state) == 2'h1 |-> periph_run && osc_enable && pc_hold)
        else $error("halt outputs wrong");
    a_halt_serial: assert property (power_state == 2'h1 && $past(power_state) == 2'h1 && $stable(serial_ext_clk_sel) |-> serial_run == serial_ext_clk_sel)
        else $error("serial run wrong in halt");
    a_pll_ce_low: assert property (s_ce_low |-> !pll_enable)
        else $error("pll on with ce low");
    a_zero_hold: assert property (power_state == 2'h2 && op_ff == 4'h0 && !ce_reset |=> power_state == 2'h2)
        else $error("stop left with zero operand");
    a_port_wake: assert property (power_state == 2'h2 && op_ff[0] && (|wake_input_port) && !ce_reset |-> ##[1:4] power_state == 2'h3)
        else $error("port wake missed");
    a_irq_wake: assert property (power_state == 2'h2 && op_ff[1] && (|(irq_enable_bit & irq_request_bit)) && !ce_reset |-> ##[1:4] power_state == 2'h3)
        else $error("irq wake missed");
    a_settle_len: assert property (power_state == 2'h0 && $past(power_state) == 2'h3 && !$past(ce_reset) |-> resume_pulse && cnt_ff == (SETTLE_FULL_CYCLES >> 1) + 24'h1)
        else $error("settle length wrong");
endmodule // standby_ctl_assertions
bind standby_ctl standby_ctl_assertions #(.NUM_IRQ(NUM_IRQ), .SETTLE_FULL_CYCLES(SETTLE_FULL_CYCLES)) standby_ctl_assertions_inst (.*);

/* dv/testbench.sv */
// Purpose: Self-checking bench for standby_ctl
// Assumes: Short settle count
// Notes: State changes matched against a queue
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0, rst = 1'b1, halt_req = 1'b0, stop_req = 1'b0;
    logic halt_release = 1'b0, ce_reset = 1'b0, ce_counter_running = 1'b0;
    logic ce_pin = 1'b0, timer_carry = 1'b0, serial_ext_clk_sel = 1'b0, arm = 1'b0;
    logic [3:0] stop_operand = 4'h0, halt_operand = 4'h0, wake_input_port;
    logic [5:0] irq_enable_bit = 6'h0, irq_request_bit = 6'h0;
    logic [7:0] dly = 8'h0;
    logic ce_counter_running_flag, pc_hold, osc_enable, periph_run, serial_run;
    logic pll_enable, ctrl_reg_init, special_pins_to_port, resume_pulse;
    logic [1:0] power_state, last_st = 2'h0;
    logic [1:0] exp_q[$];
    int mismatches = 0, total_checks = 0, seed = 20, k;
    always #2.5 ref_clk = ~ref_clk;
    standby_ctl #(.SETTLE_FULL_CYCLES(24'h000010)) standby_ctl_inst (.*);
    wake_pin_model wake_pin_model_inst (.ref_clk, .arm, .delay(dly), .wake_input_port);
    task automatic chk(input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic stop(input logic [3:0] op);
        stop_operand = op;
        stop_req = 1'b1;
        tick(1);
        stop_req = 1'b0;
    endtask
    task automatic wait_run();
        int i;
        for (i = 0; i < 300 && power_state !== 2'h0; i++)
            tick(1);
        tick(2);
        chk(1'b0, pc_hold);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Match each state change to the oldest note
    always @(negedge ref_clk)
    begin
        if (!rst && power_state !== last_st)
        begin
            last_st = power_state;
            chk(exp_q.size() ? exp_q.pop_front() : ~power_state, power_state);
        end
    end
    // Watchdog
    initial
    begin
        #100000;
        mismatches++;
        results();
    end
    // --------------------------------
    // Main sequence
    // --------------------------------
    initial
    begin
        tick(8);
        rst = 1'b0;
        ce_pin = 1'b1;
        tick(4);
        for (k = 0; k < 3; k++)
        begin
            exp_q.push_back(2'h2);
            exp_q.push_back(2'h3);
            exp_q.push_back(2'h0);
            stop(4'h1 << k);
            tick(3);
            chk(1'b0, periph_run);
            dly = 8'($unsigned($random(seed)) % 20);
            arm = (k == 0);
            irq_enable_bit[$unsigned($random(seed)) % 6] = (k == 1);
            irq_request_bit = irq_enable_bit;
            timer_carry = (k == 2);
            wait_run();
            {arm, timer_carry, irq_enable_bit, irq_request_bit} = '0;
            $display("wake test %0d done", k);
        end
        exp_q.push_back(2'h2);
        exp_q.push_back(2'h0);
        stop(4'h0);
        {arm, timer_carry, irq_enable_bit, irq_request_bit} = '1;
        tick(40);
        chk(2'h2, power_state);
        ce_reset = 1'b1;
        tick(1);
        ce_reset = 1'b0;
        {arm, timer_carry, irq_enable_bit, irq_request_bit} = '0;
        tick(4);
        $display("zero operand test done");
        ce_counter_running = 1'b1;
        tick(2);
        stop(4'h1);
        tick(4);
        chk(1'b1, ce_counter_running_flag);
        chk(2'h0, power_state);
        ce_counter_running = 1'b0;
        $display("counter no-op test done");
        serial_ext_clk_sel = $random(seed);
        halt_operand = 4'($unsigned($random(seed)));
        exp_q.push_back(2'h1);
        exp_q.push_back(2'h0);
        halt_req = 1'b1;
        tick(1);
        halt_req = 1'b0;
        ce_pin = 1'b0;
        tick(6);
        chk(serial_ext_clk_sel, serial_run);
        chk(1'b0, pll_enable);
        chk(1'b1, periph_run);
        halt_release = 1'b1;
        tick(1);
        halt_release = 1'b0;
        tick(4);
        chk(1'b1, exp_q.size() == 0);
        $display("halt test done");
        results();
    end
endmodule // testbench

/* dv/wake_pin_model.sv */
// Purpose: Model of the external wake pin
// Assumes: Driven from the falling clock edge
// Notes: Pin rises a set time after arming
`timescale 1ns/1ps
module wake_pin_model
(
    // Clock and control
    input wire logic ref_clk,
    input wire logic arm,
    input wire logic [7:0] delay,
    // Pin
    output logic [3:0] wake_input_port
);
    logic [7:0] cnt = 8'h0;
    initial wake_input_port = 4'h0;
    // Count after arming, then hold the pin high until disarmed
    always @(negedge ref_clk)
    begin
        cnt <= !arm ? 8'h0 : (cnt != delay) ? cnt + 8'h1 : cnt;
        wake_input_port <= (arm && cnt == delay) ? 4'h1 : 4'h0;
    end
endmodule // wake_pin_model

/* include/settle_if.sv */
// Purpose: Carries settle timer start and done between modules
// Assumes: Same clock on both sides
// Notes: Plain signals, no clocking block
`timescale 1ns/1ps
interface settle_if;
    logic start;
    logic [23:0] load;
    logic done;
    modport ctl (output start, output load, input done);
    modport tmr (input start, input load, output done);
endinterface

/* include/standby_ctl_defs.svh */
// Purpose: Constants for the halt and clock stop control block
// Assumes: 200 MHz ref_clk
// Notes: Included by bare name
`ifndef STANDBY_CTL_DEFS_SVH
`define STANDBY_CTL_DEFS_SVH
`define CLK_PERIOD_PS 5000
`define WAKE_COND_W 4
`define WAKE_BIT_PORT 0
`define WAKE_BIT_IRQ 1
`define WAKE_BIT_TIMER 2
`define WAKE_BIT_SPARE 3
`define SETTLE_CNT_W 24
`define SETTLE_DIV 1
`endif

/* include/standby_pkg.sv */
// Purpose: Types for the halt and clock stop control block
// Assumes: Nothing
// Notes: Used as standby_pkg::name
package standby_pkg;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HALT = 2'b01,
        ST_STOP = 2'b10,
        ST_SETTLE = 2'b11
    } power_state_t;
endpackage

/* src/settle_timer.sv */
// Purpose: Counts the oscillator settle wait after a stop wake-up
// Assumes: start is a one-cycle pulse
// Notes: done pulses once when the count runs out
`timescale 1ns/1ps
`include "standby_ctl_defs.svh"
module settle_timer
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    settle_if.tmr sif
);
    logic [`SETTLE_CNT_W-1:0] cnt_ff;
    logic busy_ff;
    logic done_ff;

    // Down counter for the settle wait
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            if (sif.start)
            begin
                cnt_ff <= sif.load;
                busy_ff <= 1'b1;
            end
            else if (busy_ff)
            begin
                if (cnt_ff <= `SETTLE_CNT_W'(1))
                begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
                else
                begin
                    cnt_ff <= cnt_ff - `SETTLE_CNT_W'(1);
                end
            end
        end
    end

    assign sif.done = done_ff;
endmodule // settle_timer

/* src/standby_ctl.sv */
// Purpose: Halt and clock stop control of a small tuning controller
// Assumes: CPU presents halt and stop instruction requests as pulses
// Notes: All inputs from pins pass two flip-flops
`timescale 1ns/1ps
`include "standby_ctl_defs.svh"
module standby_ctl
#(
    parameter int NUM_IRQ = 6,
    parameter logic [`SETTLE_CNT_W-1:0] SETTLE_FULL_CYCLES = 24'h0f0000
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // CPU requests
    input wire logic halt_req,
    input wire logic stop_req,
    input wire logic [`WAKE_COND_W-1:0] stop_operand,
    input wire logic [3:0] halt_operand,
    input wire logic halt_release,
    // Resets and counter state
    input wire logic ce_reset,
    input wire logic ce_counter_running,
    // Pins
    input wire logic ce_pin,
    input wire logic [3:0] wake_input_port,
    // Interrupt and timer state
    input wire logic [NUM_IRQ-1:0] irq_enable_bit,
    input wire logic [NUM_IRQ-1:0] irq_request_bit,
    input wire logic timer_carry,
    input wire logic serial_ext_clk_sel,
    // Status and controls
    output logic ce_counter_running_flag,
    output logic pc_hold,
    output logic osc_enable,
    output logic periph_run,
    output logic serial_run,
    output logic pll_enable,
    output logic ctrl_reg_init,
    output logic special_pins_to_port,
    output logic resume_pulse,
    output logic [1:0] power_state
);
    standby_pkg::power_state_t state_ff;
    logic ce_meta_ff, ce_sync_ff, ce_prev_ff;
    logic [3:0] port_meta_ff, port_sync_ff;
    logic [`WAKE_COND_W-1:0] wake_sel_ff;
    logic ce_rise, stop_taken, wake_hit, irq_hit;
    logic ce_counter_running_ff, pc_hold_ff, osc_enable_ff, periph_run_ff;
    logic serial_run_ff, pll_enable_ff, ctrl_reg_init_ff, special_pins_ff;
    logic resume_ff;
    settle_if sif();

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two stages for chip-enable and wake port
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ce_meta_ff <= 1'b0;
            ce_sync_ff <= 1'b0;
            ce_prev_ff <= 1'b0;
            port_meta_ff <= 4'h0;
            port_sync_ff <= 4'h0;
        end
        else
        begin
            ce_meta_ff <= ce_pin;
            ce_sync_ff <= ce_meta_ff;
            ce_prev_ff <= ce_sync_ff;
            port_meta_ff <= wake_input_port;
            port_sync_ff <= port_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Wake and request decode
    // ------------------------------------------------------------
    // Interrupt wake ignores the global enable
    assign irq_hit = |(irq_enable_bit & irq_request_bit);
    assign ce_rise = ce_sync_ff & ~ce_prev_ff;
    // Stop is taken only when no chip-enable rise or counter activity
    assign stop_taken = stop_req & ~ce_rise & ~ce_counter_running;
    // Any selected condition wakes; zero operand never matches
    assign wake_hit = (wake_sel_ff[`WAKE_BIT_PORT] & (|port_sync_ff))
        | (wake_sel_ff[`WAKE_BIT_IRQ] & irq_hit)
        | (wake_sel_ff[`WAKE_BIT_TIMER] & timer_carry);

    // Settle wait is half the selected time
    assign sif.start = (state_ff == standby_pkg::ST_STOP) && wake_hit;
    assign sif.load = SETTLE_FULL_CYCLES >> `SETTLE_DIV;

    settle_timer u_settle
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .sif(sif)
    );

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    // Resets end any low-power state
    always_ff @(posedge ref_clk)
    begin
        if (rst || ce_reset)
        begin
            state_ff <= standby_pkg::ST_RUN;
            wake_sel_ff <= '0;
        end
        else
        begin
            case (state_ff)
                standby_pkg::ST_RUN:
                begin
                    if (stop_taken)
                    begin
                        state_ff <= standby_pkg::ST_STOP;
                        wake_sel_ff <= stop_operand;
                    end
                    else if (halt_req)
                    begin
                        state_ff <= standby_pkg::ST_HALT;
                    end
                end
                standby_pkg::ST_HALT:
                begin
                    if (halt_release)
                    begin
                        state_ff <= standby_pkg::ST_RUN;
                    end
                end
                standby_pkg::ST_STOP:
                begin
                    if (wake_hit)
                    begin
                        state_ff <= standby_pkg::ST_SETTLE;
                    end
                end
                standby_pkg::ST_SETTLE:
                begin
                    if (sif.done)
                    begin
                        state_ff <= standby_pkg::ST_RUN;
                    end
                end
                default:
                begin
                    state_ff <= standby_pkg::ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Counter status flag
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ce_counter_running_ff <= 1'b0;
        end
        else
        begin
            ce_counter_running_ff <= ce_counter_running;
        end
    end

    // Program counter hold while halted, stopped or settling
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pc_hold_ff <= 1'b0;
        end
        else
        begin
            pc_hold_ff <= (state_ff != standby_pkg::ST_RUN);
        end
    end

    // Peripheral, oscillator and synthesizer enables
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            osc_enable_ff <= 1'b1;
            periph_run_ff <= 1'b1;
            serial_run_ff <= 1'b1;
            pll_enable_ff <= 1'b0;
            special_pins_ff <= 1'b0;
        end
        else
        begin
            // Oscillator runs again during the settle wait
            osc_enable_ff <= (state_ff != standby_pkg::ST_STOP);
            // Halt leaves peripherals alone except serial on internal clock; stop and settle freeze them
            periph_run_ff <= (state_ff == standby_pkg::ST_RUN)
                || (state_ff == standby_pkg::ST_HALT);
            serial_run_ff <= (state_ff == standby_pkg::ST_RUN)
                || ((state_ff == standby_pkg::ST_HALT) && serial_ext_clk_sel);
            pll_enable_ff <= ce_sync_ff && ((state_ff == standby_pkg::ST_RUN)
                || (state_ff == standby_pkg::ST_HALT));
            // Only alternate functions fall back; port latches are untouched
            special_pins_ff <= (state_ff == standby_pkg::ST_STOP)
                || (state_ff == standby_pkg::ST_SETTLE);
        end
    end

    // Control register initialise pulse on stop entry only
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctrl_reg_init_ff <= 1'b0;
        end
        else
        begin
            ctrl_reg_init_ff <= (state_ff == standby_pkg::ST_RUN) && stop_taken
                && !ce_reset;
        end
    end

    // Resume pulse when settle wait ends
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            resume_ff <= 1'b0;
        end
        else
        begin
            resume_ff <= (state_ff == standby_pkg::ST_SETTLE) && sif.done
                && !ce_reset;
        end
    end

    assign ce_counter_running_flag = ce_counter_running_ff;
    assign pc_hold = pc_hold_ff;
    assign osc_enable = osc_enable_ff;
    assign periph_run = periph_run_ff;
    assign serial_run = serial_run_ff;
    assign pll_enable = pll_enable_ff;
    assign ctrl_reg_init = ctrl_reg_init_ff;
    assign special_pins_to_port = special_pins_ff;
    assign resume_pulse = resume_ff;
    assign power_state = state_ff;
endmodule // standby_ctl
